/* include/occ_regs.vh */
/*
 * Constants for the output channel clock control block.
 * Assumes it is included by bare name from the design file.
 */
`ifndef OCC_REGS_VH
`define OCC_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OCC_IDX_CTRL        8'h2B
`define OCC_IDX_DIV         8'h2C

// ----------------------------------------------------------------
// Field positions in the output control register
// ----------------------------------------------------------------
`define OCC_SRC_HI          7
`define OCC_SRC_LO          6
`define OCC_FMT_HI          5
`define OCC_FMT_LO          4
`define OCC_MODE1_HI        3
`define OCC_MODE1_LO        2
`define OCC_MODE2_HI        1
`define OCC_MODE2_LO        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCC_CTRL_RESET      8'h18
`define OCC_DIV_RESET       8'h05

// ----------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------
`define OCC_SRC_SYNTH       2'h0
`define OCC_SRC_RSVD        2'h1
`define OCC_SRC_PRIMARY     2'h2
`define OCC_SRC_SECONDARY   2'h3

// ----------------------------------------------------------------
// Output format codes
// ----------------------------------------------------------------
`define OCC_FMT_OFF         2'h0
`define OCC_FMT_ACDIFF      2'h1
`define OCC_FMT_HCSL        2'h2
`define OCC_FMT_LVCMOS      2'h3

// ----------------------------------------------------------------
// Single-ended driver mode codes
// ----------------------------------------------------------------
`define OCC_CMOS_TRISTATE   2'h0
`define OCC_CMOS_LOW        2'h1
`define OCC_CMOS_INVERT     2'h2
`define OCC_CMOS_TRUE       2'h3

// ----------------------------------------------------------------
// AHB transfer type
// ----------------------------------------------------------------
`define OCC_HTRANS_NONSEQ   2'h2

`endif

/* rtl/occ_channel.v */
/*
 * Output channel clock control: register file on AHB-Lite, source
 * multiplexer, output divider and driver control for one channel.
 * Assumes all source clocks and the doubler enable arrive as
 * asynchronous pins, sampled on hclk, and a single AHB-Lite master.
 */
// Notes on behaviour
// R01 - Source select 0 takes the synthesizer, 2 the primary reference, 3 the secondary.
// R02 - Either reference source skips the output divider and drives the output directly.
// R03 - With the doubler enabled a reference source delivers its doubled clock.
// R04 - Format 0 disables, 1 AC differential, 2 HCSL, 3 LVCMOS, resetting to 1.
// R05 - First mode drives the positive LVCMOS pin or sets the differential tail current.
// R06 - Second mode drives the negative LVCMOS pin or sets the HCSL load, reset 0.
// R07 - The 8-bit divider divides by its value plus one and resets to ratio 6.
// R08 - The divider acts only when the synthesizer feeds the channel.
// R09 - Format 0 keeps every channel output inactive whatever the other fields say.
`timescale 1ns/1ps
`default_nettype none
`include "occ_regs.vh"

module occ_channel (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        synth_clk,
	input  wire        primary_ref_clk,
	input  wire        secondary_ref_clk,
	input  wire        primary_dbl_clk,
	input  wire        secondary_dbl_clk,
	input  wire        doubler_enable,
	output reg  [1:0]  out_format,
	output reg  [1:0]  tail_current_sel,
	output reg  [1:0]  hcsl_load_sel,
	output reg         out_p,
	output reg         out_n,
	output reg         out_p_oe_n,
	output reg         out_n_oe_n
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Maps a byte address onto a register index.
	function [7:0] addr_index;
		input [31:0] addr;
		begin
			addr_index = addr[9:2];
		end
	endfunction

	// Returns the contents of a register, zero for an unmapped index.
	function [31:0] read_word;
		input [7:0] idx;
		input [7:0] ctrl_v;
		input [7:0] div_v;
		begin
			if (idx == `OCC_IDX_CTRL) begin
				read_word = {24'h000000, ctrl_v};
			end else if (idx == `OCC_IDX_DIV) begin
				read_word = {24'h000000, div_v};
			end else begin
				read_word = 32'h00000000;
			end
		end
	endfunction

	// Drives one single-ended pin from a mode code: {level, oe_n}.
	function [1:0] cmos_pin;
		input [1:0] mode;
		input       clk;
		begin
			case (mode)
				`OCC_CMOS_TRISTATE: cmos_pin = 2'b01;
				`OCC_CMOS_LOW:      cmos_pin = 2'b00;
				`OCC_CMOS_INVERT:   cmos_pin = {~clk, 1'b0};
				`OCC_CMOS_TRUE:     cmos_pin = {clk, 1'b0};
				default:            cmos_pin = 2'b01;
			endcase
		end
	endfunction

	// Takes a new level once the second and third sample stages agree.
	function [5:0] settle;
		input [5:0] s2;
		input [5:0] s3;
		input [5:0] held;
		begin
			settle = (s2 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
		end
	endfunction

	// ----------------------------------------------------------------
	// Registers and bus slave
	// ----------------------------------------------------------------
	reg  [7:0] ctrl;
	reg  [7:0] div;
	reg        wr_pend;
	reg  [7:0] wr_idx;
	wire       addr_ok;
	wire [7:0] a_idx;
	wire [7:0] fwd_ctrl;
	wire [7:0] fwd_div;

	assign addr_ok = hsel && hready && (htrans == `OCC_HTRANS_NONSEQ);
	assign a_idx = addr_index(haddr);
	// A read right behind a write to the same register sees the new value.
	assign fwd_ctrl = (wr_pend && wr_idx == `OCC_IDX_CTRL) ? hwdata[7:0] : ctrl;
	assign fwd_div = (wr_pend && wr_idx == `OCC_IDX_DIV) ? hwdata[7:0] : div;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `OCC_CTRL_RESET; // R04 R05 R06
			div <= `OCC_DIV_RESET; // R07
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (wr_pend) begin
				if (wr_idx == `OCC_IDX_CTRL) begin
					ctrl <= hwdata[7:0];
				end
				if (wr_idx == `OCC_IDX_DIV) begin
					div <= hwdata[7:0];
				end
			end
			wr_pend <= addr_ok && hwrite;
			wr_idx <= a_idx;
			if (addr_ok && !hwrite) begin
				hrdata <= read_word(a_idx, fwd_ctrl, fwd_div);
			end else begin
				hrdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	wire [1:0] src_sel;
	wire [1:0] fmt_sel;
	wire [1:0] mode1;
	wire [1:0] mode2;

	assign src_sel = ctrl[`OCC_SRC_HI:`OCC_SRC_LO];
	assign fmt_sel = ctrl[`OCC_FMT_HI:`OCC_FMT_LO];
	assign mode1 = ctrl[`OCC_MODE1_HI:`OCC_MODE1_LO];
	assign mode2 = ctrl[`OCC_MODE2_HI:`OCC_MODE2_LO];

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	reg  [5:0] smp1;
	reg  [5:0] smp2;
	reg  [5:0] smp3;
	reg  [5:0] pin;
	wire [5:0] raw_pins;

	assign raw_pins = {doubler_enable, secondary_dbl_clk, primary_dbl_clk,
		secondary_ref_clk, primary_ref_clk, synth_clk};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smp1 <= 6'h00;
			smp2 <= 6'h00;
			smp3 <= 6'h00;
			pin <= 6'h00;
		end else begin
			smp1 <= raw_pins;
			smp2 <= smp1;
			smp3 <= smp2;
			pin <= settle(smp2, smp3, pin);
		end
	end

	// ----------------------------------------------------------------
	// Sampled pin names
	// ----------------------------------------------------------------
	wire       synth_s;
	wire       pri_ref_s;
	wire       sec_ref_s;
	wire       pri_dbl_s;
	wire       sec_dbl_s;
	wire       dbl_en_s;

	assign synth_s = pin[0];
	assign pri_ref_s = pin[1];
	assign sec_ref_s = pin[2];
	assign pri_dbl_s = pin[3];
	assign sec_dbl_s = pin[4];
	assign dbl_en_s = pin[5];

	// ----------------------------------------------------------------
	// Output divider
	// ----------------------------------------------------------------
	reg  [7:0] div_cnt;
	reg        synth_prev;
	reg        div_clk;
	wire       synth_rise;
	wire [8:0] ratio;
	wire [8:0] half;

	assign synth_rise = synth_s && !synth_prev;
	assign ratio = {1'b0, div} + 9'h001; // R07
	assign half = ratio >> 1;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 8'h00;
			synth_prev <= 1'b0;
			div_clk <= 1'b0;
		end else begin
			synth_prev <= synth_s;
			if (src_sel != `OCC_SRC_SYNTH) begin
				div_cnt <= 8'h00; // R08
				div_clk <= 1'b0;
			end else if (synth_rise) begin
				if (div_cnt >= div) begin
					div_cnt <= 8'h00;
					div_clk <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 8'h01;
					div_clk <= ({1'b0, div_cnt} + 9'h001) < half; // R07
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Source multiplexer
	// ----------------------------------------------------------------
	reg chan_clk;

	always @* begin
		case (src_sel)
			`OCC_SRC_SYNTH: chan_clk = (div == 8'h00) ? synth_s : div_clk; // R01 R08
			`OCC_SRC_PRIMARY: chan_clk = dbl_en_s ? pri_dbl_s : pri_ref_s; // R01 R02 R03
			`OCC_SRC_SECONDARY: chan_clk = dbl_en_s ? sec_dbl_s : sec_ref_s; // R01 R02 R03
			default: chan_clk = 1'b0; // R01
		endcase
	end

	// ----------------------------------------------------------------
	// Output driver control
	// ----------------------------------------------------------------
	wire [1:0] pin_p;
	wire [1:0] pin_n;

	assign pin_p = cmos_pin(mode1, chan_clk);
	assign pin_n = cmos_pin(mode2, chan_clk);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_format <= `OCC_FMT_ACDIFF;
			tail_current_sel <= 2'h2;
			hcsl_load_sel <= 2'h0;
			out_p <= 1'b0;
			out_n <= 1'b0;
			out_p_oe_n <= 1'b1;
			out_n_oe_n <= 1'b1;
		end else begin
			out_format <= fmt_sel; // R04
			tail_current_sel <= 2'h0;
			hcsl_load_sel <= 2'h0;
			case (fmt_sel)
				`OCC_FMT_OFF: begin
					out_p <= 1'b0; // R09
					out_n <= 1'b0;
					out_p_oe_n <= 1'b1;
					out_n_oe_n <= 1'b1;
				end
				`OCC_FMT_LVCMOS: begin
					out_p <= pin_p[1]; // R05
					out_p_oe_n <= pin_p[0];
					out_n <= pin_n[1]; // R06
					out_n_oe_n <= pin_n[0];
				end
				default: begin
					tail_current_sel <= mode1; // R05
					if (fmt_sel == `OCC_FMT_HCSL) begin
						hcsl_load_sel <= mode2; // R06
					end
					out_p <= chan_clk; // R04
					out_n <= ~chan_clk;
					out_p_oe_n <= 1'b0;
					out_n_oe_n <= 1'b0;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* verification/occ_channel_monitor.sv */
/*
 * Port relation checker for the output channel block.
 * Assumes it is bound to occ_channel and shares its clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
module occ_channel_monitor (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [31:0] hrdata,
	input wire logic [1:0]  out_format,
	input wire logic [1:0]  tail_current_sel,
	input wire logic [1:0]  hcsl_load_sel,
	input wire logic        out_p,
	input wire logic        out_n,
	input wire logic        out_p_oe_n,
	input wire logic        out_n_oe_n
);
	logic [1:0] fmt_q;
	logic       run_q;
	wire        steady = run_q && (fmt_q == out_format);
	wire        diff = out_format[1] != out_format[0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------------------------------
	// Format history, so that checks skip the edge where it changes.
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fmt_q <= 2'h1;
			run_q <= 1'b0;
		end else begin
			fmt_q <= out_format;
			run_q <= 1'b1;
		end
	end
	a_off_pins_low: assert property (steady && out_format == 2'h0 |-> !out_p && !out_n)
		else $error("pins not low while off");
	a_off_tristate: assert property (steady && out_format == 2'h0 |-> out_p_oe_n && out_n_oe_n)
		else $error("pins driven while off");
	a_off_no_drive: assert property (steady && out_format == 2'h0 |->
		tail_current_sel == 2'h0 && hcsl_load_sel == 2'h0)
		else $error("driver settings active while off");
	a_load_hcsl_only: assert property (steady && out_format != 2'h2 |-> hcsl_load_sel == 2'h0)
		else $error("load select outside HCSL");
	a_tail_diff_only: assert property (steady && out_format == 2'h3 |-> tail_current_sel == 2'h0)
		else $error("tail select in single ended");
	a_diff_driven: assert property (steady && diff |-> !out_p_oe_n && !out_n_oe_n)
		else $error("differential pins not driven");
	a_diff_compl: assert property (steady && diff |-> out_n != out_p)
		else $error("differential pins not complementary");
	a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule
bind occ_channel occ_channel_monitor occ_channel_monitor_i (
	.hclk             (hclk),
	.hresetn          (hresetn),
	.hrdata           (hrdata),
	.out_format       (out_format),
	.tail_current_sel (tail_current_sel),
	.hcsl_load_sel    (hcsl_load_sel),
	.out_p            (out_p),
	.out_n            (out_n),
	.out_p_oe_n       (out_p_oe_n),
	.out_n_oe_n       (out_n_oe_n)
);
`default_nettype wire

/* verification/tb_occ_channel.sv */
/*
 * Self-checking bench for the output channel block.
 * Assumes the register header is on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "occ_regs.vh"
module tb_occ_channel;
	logic        hclk, hresetn, hsel, hwrite, doubler_enable, prev;
	logic        synth_clk, primary_ref_clk, secondary_ref_clk, primary_dbl_clk, secondary_dbl_clk;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0]  htrans;
	logic [7:0]  v;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, out_p, out_n, out_p_oe_n, out_n_oe_n;
	wire  [1:0]  out_format, tail_current_sel, hcsl_load_sel;
	integer      seed = 85366, errors = 0, cmp_count = 0, cyc = 0, k, n;
	occ_channel occ_channel_i (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (3'h2),
		.hwdata            (hwdata),
		.hready            (hreadyout),
		.hrdata            (hrdata),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.synth_clk         (synth_clk),
		.primary_ref_clk   (primary_ref_clk),
		.secondary_ref_clk (secondary_ref_clk),
		.primary_dbl_clk   (primary_dbl_clk),
		.secondary_dbl_clk (secondary_dbl_clk),
		.doubler_enable    (doubler_enable),
		.out_format        (out_format),
		.tail_current_sel  (tail_current_sel),
		.hcsl_load_sel     (hcsl_load_sel),
		.out_p             (out_p),
		.out_n             (out_n),
		.out_p_oe_n        (out_p_oe_n),
		.out_n_oe_n        (out_n_oe_n)
	);
	initial begin
		hclk = 0;
		forever #10 hclk = ~hclk;
	end
	// ----------------------------------------------------------------
	// Source pins at fixed periods, and the run limit.
	// ----------------------------------------------------------------
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		synth_clk <= cyc % 8 < 4;
		primary_ref_clk <= cyc % 12 < 6;
		secondary_ref_clk <= cyc % 20 < 10;
		primary_dbl_clk <= cyc % 6 < 3;
		secondary_dbl_clk <= cyc % 10 < 5;
		if (cyc == 20000) begin
			errors = errors + 1;
			summarize;
		end
	end
	task summarize;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[ERR] %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	function logic [1:0] exp_tail(input logic [1:0] f, input logic [1:0] m);
		return (f == 2'h1 || f == 2'h2) ? m : 2'h0;
	endfunction
	function logic [1:0] exp_load(input logic [1:0] f, input logic [1:0] m);
		return (f == 2'h2) ? m : 2'h0;
	endfunction
	// Runs the channel as LVCMOS and counts output rises over 480 cycles.
	task run_clk(input logic [1:0] src, input logic dbl, input logic [7:0] div, input integer per);
		doubler_enable <= dbl;
		xfer(1, `OCC_IDX_DIV, div);
		xfer(1, `OCC_IDX_CTRL, {src, 6'h3E});
		repeat (40) @(posedge hclk);
		n = 0;
		prev = out_p;
		for (k = 0; k < 480; k++) begin
			@(posedge hclk);
			if (out_p && !prev) n = n + 1;
			prev = out_p;
		end
		chk("edges", n >= 480 / per - 1 && n <= 480 / per + 1, 32'h1);
		chk("out_n", out_n, !out_p);
	endtask
	initial begin
		{hresetn, hwrite, doubler_enable, htrans, haddr, hwdata} = '0;
		hsel = 1;
		repeat (8) @(posedge hclk);
		hresetn <= 1;
		chk("fmt", out_format, 2'h1);
		chk("tail", tail_current_sel, 2'h2);
		xfer(0, `OCC_IDX_CTRL, 8'h00);
		chk("ctrl", rd, 32'h18);
		xfer(0, `OCC_IDX_DIV, 8'h00);
		chk("div", rd, 32'h05);
		xfer(1, 8'h40, 8'h5A);
		xfer(0, 8'h40, 8'h00);
		chk("unmapped", rd, 32'h0);
		for (k = 0; k < 8; k++) begin
			v = 8'($random(seed));
			xfer(1, `OCC_IDX_DIV, v);
			xfer(0, `OCC_IDX_DIV, 8'h00);
			chk("div", rd, {24'h0, v});
			v[7:4] = {{2{k[0]}}, k[2:1]};
			xfer(1, `OCC_IDX_CTRL, v);
			xfer(0, `OCC_IDX_CTRL, 8'h00);
			chk("ctrl", rd, {24'h0, v});
			chk("fmt", out_format, v[5:4]);
			chk("tail", tail_current_sel, exp_tail(v[5:4], v[3:2]));
			chk("load", hcsl_load_sel, exp_load(v[5:4], v[1:0]));
			if (v[5:4] == 2'h0) chk("off", {out_p_oe_n, out_n_oe_n, out_p, out_n}, 4'hC);
		end
		hresetn <= 0;
		@(posedge hclk);
		chk("fmt_rst", {out_format, tail_current_sel, hcsl_load_sel}, 6'h18);
		chk("pin_rst", {hreadyout, hresp, out_p, out_n, out_p_oe_n, out_n_oe_n}, 6'h23);
		hresetn <= 1;
		xfer(0, `OCC_IDX_CTRL, 8'h00);
		chk("ctrl_rst", rd, {24'h0, `OCC_CTRL_RESET});
		xfer(0, `OCC_IDX_DIV, 8'h00);
		chk("div_rst", rd, {24'h0, `OCC_DIV_RESET});
		v = 8'($random(seed) & 3);
		run_clk(2'h0, 0, v, 8 * (v + 1));
		run_clk(2'h0, 0, `OCC_DIV_RESET, 48);
		run_clk(2'h0, 1, 8'h00, 8);
		run_clk(2'h2, 0, 8'h07, 12);
		run_clk(2'h2, 1, 8'h07, 6);
		run_clk(2'h3, 0, 8'h03, 20);
		run_clk(2'h3, 1, 8'h00, 10);
		run_clk(2'h1, 0, 8'h00, 100000);
		summarize;
	end
endmodule
`default_nettype wire
